// ### core/pld_module_io_port_logic.sv
// Module: run-time I/O logic for ports A..D of the programmable-logic module
// Notes on behaviour
// - Sample registers return current pin levels; A 00h, B 01h, C 10h, D 11h.
// - Unimplemented port C and D sample bits are undefined; here read zero.
// - Output-value bits set the driven level; A 04h, B 05h, C 12h, D 13h.
// - Output-value registers clear to 00h at reset.
// - Direction bit 1 is output, 0 input; A 06h, B 07h, C 14h, D 15h.
// - After reset all pins are high-impedance inputs unless an array output-enable drives them.
// - Pin enable is array output-enable OR direction bit.
// - An active array output-enable drives the pin even with direction cleared.
// - Ports A-C reach the array through input macrocells; port D directly.
// - A-C may carry general array outputs; D carries decode array chip selects.
// - Array-output pins ignore the output-value register and address output; their direction bit still enables the pin.
// - Array-input pins stay readable and their direction bit still acts.
// - Macrocells used as internal nodes leave their pins free.
// - Address-out bit 1 drives an address bit; A at 02h, B at 03h.
// - Port A pin n carries A[n]; port B low or high byte by configuration.
// - Address output is chosen per pin independently.
// - Port A address enable and A, D direction clear to 00h.
// - Address captured at the latch strobe and held during data phase.
// - Port A absent on the small package variant.
`timescale 1ns/10ps
module pld_module_io_port_logic
    import pld_io_pkg::*;
#(
    parameter bit HAS_PORT_A = 1'b1, // Cleared for the small package
    parameter bit PORT_B_HIGH_BYTE = 1'b0 // Port B carries A8..A15 when set
) (
    input wire logic i_clk, // System clock, 20 MHz
    input wire logic i_rst_n, // Sync reset, low active
    input wire reg_req_t i_req, // Register access from processor
    output logic [7:0] o_rdata, // Read data, one cycle after request
    output logic o_rvalid, // Read data valid pulse
    input wire logic i_ale, // Address latch strobe
    input wire logic [15:0] i_ad, // Multiplexed address/data bus
    input wire pld_ctl_t i_pld_a, // Array controls for port A
    input wire pld_ctl_t i_pld_b, // Array controls for port B
    input wire pld_ctl_t i_pld_c, // Array controls for port C
    input wire pld_ctl_t i_pld_d, // Decode array chip selects for port D
    input wire logic [7:0] i_first_port_pins, // Port A pin levels
    input wire logic [7:0] i_second_port_pins, // Port B pin levels
    input wire logic [7:0] i_third_port_pins, // Port C pin levels
    input wire logic [7:0] i_fourth_port_pins, // Port D pin levels
    output logic [7:0] o_first_port_pins, // Port A drive level
    output logic [7:0] o_second_port_pins, // Port B drive level
    output logic [7:0] o_third_port_pins, // Port C drive level
    output logic [7:0] o_fourth_port_pins, // Port D drive level
    output logic [7:0] o_first_port_oe, // Port A output enable
    output logic [7:0] o_second_port_oe, // Port B output enable
    output logic [7:0] o_third_port_oe, // Port C output enable
    output logic [7:0] o_fourth_port_oe, // Port D output enable
    output logic [7:0] o_input_macrocell_a, // Port A to input macrocells
    output logic [7:0] o_input_macrocell_b, // Port B to input macrocells
    output logic [7:0] o_input_macrocell_c, // Port C to input macrocells
    output logic [7:0] o_array_in_d // Port D straight to array input bus
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [31:0] pins_sync;

    pin_sync #(.W(32)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_fourth_port_pins, i_third_port_pins, i_second_port_pins,
                  i_first_port_pins}),
        .o_sync(pins_sync)
    );

    logic [7:0] mask_a_eff;
    assign mask_a_eff = HAS_PORT_A ? MASK_A : 8'h00;

    logic [7:0] sync_a, sync_b, sync_c, sync_d;
    assign sync_a = pins_sync[7:0] & mask_a_eff;
    assign sync_b = pins_sync[15:8] & MASK_B;
    assign sync_c = pins_sync[23:16] & MASK_C;
    assign sync_d = pins_sync[31:24] & MASK_D;

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] a_addr_en_ff, b_addr_en_ff;
    logic [7:0] a_out_ff, b_out_ff, c_out_ff, d_out_ff;
    logic [7:0] a_dir_ff, b_dir_ff, c_dir_ff, d_dir_ff;
    logic wr;
    assign wr = i_req.sel && i_req.wr;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            a_addr_en_ff <= RST_REG;
            b_addr_en_ff <= RST_REG;
        end else if (wr) begin
            if (i_req.ofs == OFS_A_ADDR_EN)
                a_addr_en_ff <= i_req.wdata & mask_a_eff;
            if (i_req.ofs == OFS_B_ADDR_EN)
                b_addr_en_ff <= i_req.wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            a_out_ff <= RST_REG;
            b_out_ff <= RST_REG;
            c_out_ff <= RST_REG;
            d_out_ff <= RST_REG;
        end else if (wr) begin
            unique case (i_req.ofs)
                OFS_A_OUT: a_out_ff <= i_req.wdata & mask_a_eff;
                OFS_B_OUT: b_out_ff <= i_req.wdata & MASK_B;
                OFS_C_OUT: c_out_ff <= i_req.wdata & MASK_C;
                OFS_D_OUT: d_out_ff <= i_req.wdata & MASK_D;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            a_dir_ff <= RST_REG;
            b_dir_ff <= RST_REG;
            c_dir_ff <= RST_REG;
            d_dir_ff <= RST_REG;
        end else if (wr) begin
            unique case (i_req.ofs)
                OFS_A_DIR: a_dir_ff <= i_req.wdata & mask_a_eff;
                OFS_B_DIR: b_dir_ff <= i_req.wdata & MASK_B;
                OFS_C_DIR: c_dir_ff <= i_req.wdata & MASK_C;
                OFS_D_DIR: d_dir_ff <= i_req.wdata & MASK_D;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets and absent port A return zero
    logic [7:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (i_req.ofs)
            OFS_A_SAMPLE: nxt_rdata = sync_a;
            OFS_B_SAMPLE: nxt_rdata = sync_b;
            OFS_C_SAMPLE: nxt_rdata = sync_c;
            OFS_D_SAMPLE: nxt_rdata = sync_d;
            OFS_A_ADDR_EN: nxt_rdata = a_addr_en_ff;
            OFS_B_ADDR_EN: nxt_rdata = b_addr_en_ff;
            OFS_A_OUT: nxt_rdata = a_out_ff;
            OFS_B_OUT: nxt_rdata = b_out_ff;
            OFS_C_OUT: nxt_rdata = c_out_ff;
            OFS_D_OUT: nxt_rdata = d_out_ff;
            OFS_A_DIR: nxt_rdata = a_dir_ff;
            OFS_B_DIR: nxt_rdata = b_dir_ff;
            OFS_C_DIR: nxt_rdata = c_dir_ff;
            OFS_D_DIR: nxt_rdata = d_dir_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    logic [7:0] rdata_ff;
    logic rvalid_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= i_req.sel && i_req.rd;
            if (i_req.sel && i_req.rd)
                rdata_ff <= nxt_rdata;
        end
    end
    assign o_rdata = rdata_ff;
    assign o_rvalid = rvalid_ff;

    // ****************************************
    // Address latch
    // ****************************************
    // Captured while the strobe is high, held through the data phase
    logic [15:0] addr_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            addr_ff <= 16'h0000;
        else if (i_ale)
            addr_ff <= i_ad;
    end
    logic [7:0] addr_b;
    assign addr_b = PORT_B_HIGH_BYTE ? addr_ff[15:8] : addr_ff[7:0];

    // ****************************************
    // Pin drive
    // ****************************************
    // Priority per pin: array output, then address output, then MCU I/O
    function automatic logic [15:0] pin_mux(
        input logic [7:0] sel,
        input logic [7:0] oe,
        input logic [7:0] pld_dat,
        input logic [7:0] adr_en,
        input logic [7:0] adr,
        input logic [7:0] dout,
        input logic [7:0] dir,
        input logic [7:0] mask
    );
        logic [7:0] lvl;
        logic [7:0] en;
        lvl = 8'h00;
        en = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (sel[i]) begin
                lvl[i] = pld_dat[i];
                en[i] = oe[i] | dir[i];
            end else if (adr_en[i]) begin
                lvl[i] = adr[i];
                en[i] = oe[i] | dir[i];
            end else begin
                lvl[i] = dout[i];
                en[i] = oe[i] | dir[i];
            end
        end
        return {lvl & mask, en & mask};
    endfunction : pin_mux

    logic [15:0] nxt_a, nxt_b, nxt_c, nxt_d;
    assign nxt_a = pin_mux(i_pld_a.pld_out_sel, i_pld_a.pld_oe, i_pld_a.pld_data,
                           a_addr_en_ff, addr_ff[7:0], a_out_ff, a_dir_ff, mask_a_eff);
    assign nxt_b = pin_mux(i_pld_b.pld_out_sel, i_pld_b.pld_oe, i_pld_b.pld_data,
                           b_addr_en_ff, addr_b, b_out_ff, b_dir_ff, MASK_B);
    assign nxt_c = pin_mux(i_pld_c.pld_out_sel, i_pld_c.pld_oe, i_pld_c.pld_data,
                           8'h00, 8'h00, c_out_ff, c_dir_ff, MASK_C);
    assign nxt_d = pin_mux(i_pld_d.pld_out_sel, i_pld_d.pld_oe, i_pld_d.pld_data,
                           8'h00, 8'h00, d_out_ff, d_dir_ff, MASK_D);

    logic [63:0] drive_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            drive_ff <= '0;
        else
            drive_ff <= {nxt_d, nxt_c, nxt_b, nxt_a};
    end
    assign o_first_port_pins = drive_ff[15:8];
    assign o_first_port_oe = drive_ff[7:0];
    assign o_second_port_pins = drive_ff[31:24];
    assign o_second_port_oe = drive_ff[23:16];
    assign o_third_port_pins = drive_ff[47:40];
    assign o_third_port_oe = drive_ff[39:32];
    assign o_fourth_port_pins = drive_ff[63:56];
    assign o_fourth_port_oe = drive_ff[55:48];

    // ****************************************
    // Array input paths
    // ****************************************
    logic [31:0] arr_in_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            arr_in_ff <= '0;
        else
            arr_in_ff <= {sync_d, sync_c, sync_b, sync_a};
    end
    assign o_input_macrocell_a = arr_in_ff[7:0];
    assign o_input_macrocell_b = arr_in_ff[15:8];
    assign o_input_macrocell_c = arr_in_ff[23:16];
    assign o_array_in_d = arr_in_ff[31:24];

    // ****************************************
    // Assertions: reset state
    // ****************************************
    // The first edge after a release still shows the reset outputs
    a_dir_reset: assert property (@(posedge i_clk)
        !i_rst_n |=> a_dir_ff == 8'h00 && d_dir_ff == 8'h00 && a_addr_en_ff == 8'h00)
        else $error("reset values wrong");
    a_out_reset: assert property (@(posedge i_clk)
        !i_rst_n |=> b_out_ff == 8'h00 && d_out_ff == 8'h00)
        else $error("output value not cleared");
    a_pins_float: assert property (@(posedge i_clk)
        !i_rst_n |=> o_third_port_oe == 8'h00)
        else $error("pin enabled during reset");

    // ****************************************
    // Assertions: register bus
    // ****************************************
    a_write_dir: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (wr && i_req.ofs == OFS_D_DIR) |=> d_dir_ff == ($past(i_req.wdata) & MASK_D))
        else $error("direction write wrong");
    a_read_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_req.sel && i_req.rd) |=> o_rvalid)
        else $error("read not answered next cycle");
    a_read_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_req.sel && i_req.rd) |=> !o_rvalid)
        else $error("read valid without a read");
    a_rdata_stands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_req.sel && i_req.rd) |=> $stable(o_rdata))
        else $error("read data changed without a read");
    a_unimpl_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ((c_out_ff | c_dir_ff) & ~MASK_C) == 8'h00
        && ((d_out_ff | d_dir_ff) & ~MASK_D) == 8'h00)
        else $error("unimplemented bit stored");

    // ****************************************
    // Assertions: pin drive and array paths
    // ****************************************
    a_oe_merge: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_second_port_oe == $past(i_pld_b.pld_oe | b_dir_ff))
        else $error("port B enable not OR of array enable and direction");
    a_oe_merge_c: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_third_port_oe == $past((i_pld_c.pld_oe | c_dir_ff) & MASK_C))
        else $error("port C enable not OR of array enable and direction");
    a_pld_oe_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_pld_b.pld_oe[0] && b_dir_ff[0] == 1'b0) |=> o_second_port_oe[0])
        else $error("array enable did not drive pin");
    a_pld_owns_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_pld_b.pld_out_sel[0] |=> o_second_port_pins[0] == $past(i_pld_b.pld_data[0]))
        else $error("array output not driven");
    a_chip_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_pld_d.pld_out_sel[1] |=> o_fourth_port_pins[1] == $past(i_pld_d.pld_data[1]))
        else $error("chip select not driven on port D");
    a_addr_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ale ##1 !i_ale) |=> addr_ff == $past(i_ad, 2))
        else $error("latched address not held");
    a_addr_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (a_addr_en_ff[0] && !i_pld_a.pld_out_sel[0])
        |=> o_first_port_pins[0] == $past(addr_ff[0] & mask_a_eff[0]))
        else $error("port A pin 0 not carrying address bit");
    a_byte_select: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (b_addr_en_ff[0] && !i_pld_b.pld_out_sel[0])
        |=> o_second_port_pins[0] == $past(PORT_B_HIGH_BYTE ? addr_ff[8] : addr_ff[0]))
        else $error("port B pin 0 carrying wrong address byte");
    a_absent_port: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !HAS_PORT_A |-> o_first_port_oe == 8'h00 && a_out_ff == 8'h00 && a_dir_ff == 8'h00)
        else $error("absent port A became active");
    a_array_input: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_array_in_d == $past(sync_d)
        && o_input_macrocell_c == $past(sync_c))
        else $error("array input path wrong");

    // ****************************************
    // Coverage of the main scenarios
    // ****************************************
    c_addr_out: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        |b_addr_en_ff && i_ale);
    c_pld_pin: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        |i_pld_c.pld_out_sel);
    c_read_d: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.sel && i_req.rd && i_req.ofs == OFS_D_SAMPLE);
    c_array_over_addr: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        |(i_pld_b.pld_out_sel & b_addr_en_ff));
    c_chip_select: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        |i_pld_d.pld_out_sel);
endmodule : pld_module_io_port_logic

// ### core/pld_io_pkg.sv
// Package: offsets, widths, reset values and carriers for the PLD module I/O port logic
package pld_io_pkg;
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_A_SAMPLE = 8'h00;
    localparam logic [7:0] OFS_B_SAMPLE = 8'h01;
    localparam logic [7:0] OFS_A_ADDR_EN = 8'h02;
    localparam logic [7:0] OFS_B_ADDR_EN = 8'h03;
    localparam logic [7:0] OFS_A_OUT = 8'h04;
    localparam logic [7:0] OFS_B_OUT = 8'h05;
    localparam logic [7:0] OFS_A_DIR = 8'h06;
    localparam logic [7:0] OFS_B_DIR = 8'h07;
    localparam logic [7:0] OFS_C_SAMPLE = 8'h10;
    localparam logic [7:0] OFS_D_SAMPLE = 8'h11;
    localparam logic [7:0] OFS_C_OUT = 8'h12;
    localparam logic [7:0] OFS_D_OUT = 8'h13;
    localparam logic [7:0] OFS_C_DIR = 8'h14;
    localparam logic [7:0] OFS_D_DIR = 8'h15;
    localparam logic [7:0] RST_REG = 8'h00;
    // Implemented bits per port
    localparam logic [7:0] MASK_A = 8'hFF;
    localparam logic [7:0] MASK_B = 8'hFF;
    localparam logic [7:0] MASK_C = 8'h9C;
    localparam logic [7:0] MASK_D = 8'h06;
    // Register bus request from the processor
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] ofs;
        logic [7:0] wdata;
    } reg_req_t;
    // Per-port programmable-array control
    typedef struct packed {
        logic [7:0] pld_out_sel;
        logic [7:0] pld_oe;
        logic [7:0] pld_data;
    } pld_ctl_t;
endpackage : pld_io_pkg

// ### core/pin_sync.sv
// Module: two-stage synchroniser for a bank of pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int unsigned W = 8
) (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Sync reset, low active
    input wire logic [W-1:0] i_async, // Raw pin levels
    output logic [W-1:0] o_sync // Synchronised levels
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : pin_sync

// ### verification/pin_world.sv
// Pin-side model: resolves every port wire from device and external drivers
`timescale 1ns/10ps
module pin_world #(
    parameter int unsigned W = 32
) (
    input wire logic [W-1:0] i_oe, // Device output enable
    input wire logic [W-1:0] i_out, // Device drive level
    input wire logic [W-1:0] i_ext_en, // External driver active
    input wire logic [W-1:0] i_ext_val, // External drive level
    output logic [W-1:0] o_level // Resolved wire level
);
    // Undriven pins sit on the weak pull-up, never on a stale value
    always_comb begin
        for (int k = 0; k < W; k++) begin
            o_level[k] = i_oe[k] ? i_out[k] : (i_ext_en[k] ? i_ext_val[k] : 1'b1);
        end
    end
endmodule : pin_world

// ### verification/tb_pld_module_io_port_logic.sv
// Testbench: register access, pin driving, sampling and address output
`timescale 1ns/10ps
module tb_pld_module_io_port_logic import pld_io_pkg::*; ;
    localparam logic [7:0] OFS_T [0:9] = '{OFS_A_ADDR_EN, OFS_B_ADDR_EN, OFS_A_OUT, OFS_B_OUT,
        OFS_A_DIR, OFS_B_DIR, OFS_C_OUT, OFS_D_OUT, OFS_C_DIR, OFS_D_DIR};
    localparam logic [7:0] MSK_T [0:9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        MASK_C, MASK_D, MASK_C, MASK_D};
    logic i_clk, i_rst_n, i_ale, o_rvalid;
    logic [15:0] i_ad;
    reg_req_t i_req;
    pld_ctl_t pld_a, pld_b, pld_c, pld_d;
    logic [7:0] o_rdata, pa_o, pb_o, pc_o, pd_o, pa_oe, pb_oe, pc_oe, pd_oe;
    logic [7:0] mc_a, mc_b, mc_c, arr_d, rv;
    logic [7:0] rd2, pa_o2, pa_oe2, pb_o2;
    logic [31:0] ext_en, ext_val, lvl;
    int errors, compares;

    pin_world #(.W(32)) pin_world_i (.i_oe({pa_oe, pb_oe, pc_oe, pd_oe}),
        .i_out({pa_o, pb_o, pc_o, pd_o}), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(lvl));

    pld_module_io_port_logic pld_module_io_port_logic_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_ale(i_ale), .i_ad(i_ad),
        .i_pld_a(pld_a), .i_pld_b(pld_b), .i_pld_c(pld_c), .i_pld_d(pld_d),
        .i_first_port_pins(lvl[31:24]), .i_second_port_pins(lvl[23:16]),
        .i_third_port_pins(lvl[15:8]), .i_fourth_port_pins(lvl[7:0]),
        .o_first_port_pins(pa_o), .o_second_port_pins(pb_o), .o_third_port_pins(pc_o),
        .o_fourth_port_pins(pd_o), .o_first_port_oe(pa_oe), .o_second_port_oe(pb_oe),
        .o_third_port_oe(pc_oe), .o_fourth_port_oe(pd_oe), .o_input_macrocell_a(mc_a),
        .o_input_macrocell_b(mc_b), .o_input_macrocell_c(mc_c), .o_array_in_d(arr_d));

    // Small package build, port B on the high address byte; listens on the same bus
    pld_module_io_port_logic #(.HAS_PORT_A(1'b0), .PORT_B_HIGH_BYTE(1'b1))
        small_pld_module_io_port_logic_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req),
        .o_rdata(rd2), .o_rvalid(), .i_ale(i_ale), .i_ad(i_ad), .i_pld_a(pld_a),
        .i_pld_b(pld_b), .i_pld_c(pld_c), .i_pld_d(pld_d), .i_first_port_pins(lvl[31:24]),
        .i_second_port_pins(lvl[23:16]), .i_third_port_pins(lvl[15:8]),
        .i_fourth_port_pins(lvl[7:0]), .o_first_port_pins(pa_o2), .o_second_port_pins(pb_o2),
        .o_third_port_pins(), .o_fourth_port_pins(), .o_first_port_oe(pa_oe2),
        .o_second_port_oe(), .o_third_port_oe(), .o_fourth_port_oe(),
        .o_input_macrocell_a(), .o_input_macrocell_b(), .o_input_macrocell_c(),
        .o_array_in_d());

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{1'b1, 1'b1, 1'b0, ofs, d};
        @(posedge i_clk);
        i_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_req <= '{1'b1, 1'b0, 1'b1, ofs, 8'h00};
        @(posedge i_clk);
        i_req <= '0;
        #1;
        while (o_rvalid !== 1'b1 && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk({7'h00, o_rvalid}, 8'h01);
        chk(n[7:0], 8'h00);
        d = o_rdata;
    endtask : rd

    // Pin outputs follow a write two edges later; two spare edges of margin
    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : settle

    task automatic results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        errors++;
        results();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        i_rst_n = 1'b0;
        i_req = '0;
        i_ale = 1'b0;
        i_ad = 16'h0000;
        pld_a = '0;
        pld_b = '0;
        pld_d = '0;
        pld_c = '{8'h04, 8'h04, 8'h04};
        ext_en = '0;
        ext_val = '0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        settle();
        chk(pc_oe, 8'h04);
        chk(pa_oe | pb_oe | pd_oe, 8'h00);
        chk(pc_o & 8'h04, 8'h04);
        pld_c <= '0;
        for (int i = 0; i < 10; i++) begin
            rd(OFS_T[i], rv);
            chk(rv, 8'h00);
            wr(OFS_T[i], 8'hFF);
            rd(OFS_T[i], rv);
            chk(rv, MSK_T[i]);
            wr(OFS_T[i], 8'h00);
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, rv);
        chk(rv, 8'h00);
        // Mixed directions inside ports A and B, all of C and D outputs; outside world drives the inputs
        wr(OFS_A_OUT, 8'hA5);
        wr(OFS_B_OUT, 8'h3C);
        wr(OFS_C_OUT, 8'hFF);
        wr(OFS_D_OUT, 8'hFF);
        wr(OFS_A_DIR, 8'h0F);
        wr(OFS_B_DIR, 8'hF0);
        wr(OFS_C_DIR, 8'hFF);
        wr(OFS_D_DIR, 8'hFF);
        ext_en <= {8'hF0, 8'h0F, 8'h63, 8'hF9};
        ext_val <= {8'h3C, 8'h69, 8'h00, 8'h00};
        settle();
        chk(pa_oe, 8'h0F);
        chk(pb_oe, 8'hF0);
        chk(pc_oe, MASK_C);
        chk(pd_oe, MASK_D);
        chk(pa_o & pa_oe, 8'h05);
        chk(pb_o & pb_oe, 8'h30);
        chk(pc_o & pc_oe, 8'h9C);
        chk(pd_o & pd_oe, 8'h06);
        rd(OFS_A_SAMPLE, rv);
        chk(rv, 8'h35);
        chk(rd2, 8'h00);
        rd(OFS_B_SAMPLE, rv);
        chk(rv, 8'h39);
        rd(OFS_C_SAMPLE, rv);
        chk(rv & MASK_C, 8'h9C);
        rd(OFS_D_SAMPLE, rv);
        chk(rv & MASK_D, 8'h06);
        chk(mc_a, 8'h35);
        chk(mc_b, 8'h39);
        chk(mc_c & MASK_C, 8'h9C);
        chk(arr_d & MASK_D, 8'h06);
        // Address on low half of port A, all of port B; data phase changes the bus
        ext_en <= '0;
        wr(OFS_A_ADDR_EN, 8'h0F);
        wr(OFS_A_DIR, 8'hFF);
        wr(OFS_A_OUT, 8'hF0);
        wr(OFS_B_ADDR_EN, 8'hFF);
        wr(OFS_B_DIR, 8'hFF);
        @(posedge i_clk);
        i_ale <= 1'b1;
        i_ad <= 16'h12A5;
        @(posedge i_clk);
        i_ale <= 1'b0;
        i_ad <= 16'h5A00;
        settle();
        chk(pa_o, 8'hF5);
        chk(pb_o, 8'hA5);
        chk(pb_o2, 8'h12);
        chk(pa_oe2 | pa_o2, 8'h00);
        // Array takes two port B pins over address and output-value settings
        wr(OFS_B_OUT, 8'hFF);
        wr(OFS_B_DIR, 8'h00);
        pld_b <= '{8'h81, 8'h81, 8'h01};
        pld_d <= '{8'h02, 8'h02, 8'h00};
        settle();
        chk(pb_oe, 8'h81);
        chk(pb_o & pb_oe, 8'h01);
        chk(pb_o & 8'h7E, 8'h24);
        chk(pd_o & pd_oe, 8'h04);
        // Reset again in mid-run
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        settle();
        chk(pb_oe, 8'h81);
        chk(pd_oe, 8'h02);
        rd(OFS_A_OUT, rv);
        chk(rv, 8'h00);
        results();
    end
endmodule : tb_pld_module_io_port_logic
